// ===== dv/cnt_core_properties.sv
`timescale 1ns/1ps
module cnt_core_checker #(
    parameter int UNIT_CYCLES = 20
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic src_in,
    input wire logic gate_in,
    input wire logic dout
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////
    // bus phase decode
    logic acc;
    logic bad;
    logic wr0;
    assign acc = psel && penable;
    assign bad = paddr > cnt_pkg::OFS_STAT || paddr[1:0] != 2'h0;
    assign wr0 = acc && pwrite && paddr == cnt_pkg::OFS_OUT0;

    // read setup of a given word straight after the command write
    sequence rd_next(a);
        ##1 (psel && !penable && !pwrite && paddr == a) ##1 penable;
    endsequence

    ////////////////////////////////////////////////////////////////
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_unmapped_err: assert property (acc && bad |-> pslverr)
        else $error("no slave error on unmapped access");
    a_mapped_ok: assert property (acc && !bad |-> !pslverr)
        else $error("slave error on mapped access");
    a_unmapped_zero: assert property (acc && bad && !pwrite |-> prdata == 32'h0)
        else $error("unmapped read data not zero");
    a_gate_echo: assert property (wr0 && pwdata[15:10] == cnt_pkg::CMD_FREQ
        && pwdata[9:0] >= cnt_pkg::GATE_HIGH ##0 rd_next(cnt_pkg::OFS_IN0)
        |-> prdata[15:0] == $past(pwdata[15:0], 2))
        else $error("frequency command not echoed");
    a_bad_factor: assert property (wr0 && pwdata[15:10] == cnt_pkg::CMD_FREQ
        && (pwdata[9:0] == 10'h000 || pwdata[9:0] inside {[10'h3e9:10'h3fb]})
        ##0 rd_next(cnt_pkg::OFS_IN0) |-> prdata[15])
        else $error("bad factor not flagged");
    a_undef_code: assert property (wr0 && pwdata[15:10] inside {6'h01, 6'h02, 6'h03}
        ##0 rd_next(cnt_pkg::OFS_IN0) |-> prdata[15])
        else $error("undefined code not flagged");
    a_fw_word: assert property (wr0 && pwdata[15:10] == cnt_pkg::CMD_FWVER
        ##3 (psel && !penable && paddr == cnt_pkg::OFS_IN1) ##1 penable
        |-> prdata[15:0] == cnt_pkg::FW_VERSION)
        else $error("firmware word wrong");

    c_freq: cover property (wr0 && pwdata[15:10] == cnt_pkg::CMD_FREQ);
    c_read: cover property (wr0 && pwdata[15:10] == cnt_pkg::CMD_READ);
    c_unmapped: cover property (acc && bad);
    c_dout: cover property ($rose(dout));
endmodule

bind cnt_core cnt_core_checker #(.UNIT_CYCLES(UNIT_CYCLES)) u_cnt_core_checker (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_in(src_in), .gate_in(gate_in), .dout(dout));

// ===== dv/ctrl_board.sv
`timescale 1ns/1ps
// controller board model: apb master exchanging the process data words
module ctrl_board (
    input wire logic pclk,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    ////////////////////////////////////////////////////////////////
    // one transfer; psel stays up so a next setup may follow at once
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        penable <= 1'b0;
    endtask

    task automatic idle();
        psel <= 1'b0;
        @(posedge pclk);
    endtask

    // parameter word first, command word executes, then both input words
    task automatic cmd(input logic [15:0] o1, input logic [15:0] o0,
                       output logic [31:0] i0, output logic [31:0] i1);
        logic [31:0] q;
        logic e;
        xfer(1'b1, cnt_pkg::OFS_OUT1, {16'h0000, o1}, q, e);
        xfer(1'b1, cnt_pkg::OFS_OUT0, {16'h0000, o0}, q, e);
        xfer(1'b0, cnt_pkg::OFS_IN0, 32'h0, i0, e);
        xfer(1'b0, cnt_pkg::OFS_IN1, 32'h0, i1, e);
        idle();
    endtask
endmodule

// ===== dv/test_counter_command_and_frequency_measure.sv
`timescale 1ns/1ps
module test_counter_command_and_frequency_measure;
    localparam int UNIT = 20;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, dout, e;
    logic src_in = 1'b0;
    logic gate_in = 1'b0;
    logic gate_en = 1'b0;
    logic [4:0] ph = 5'h00;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q0, q1;
    int errors = 0;
    int n_compared = 0;

    always #2.5 pclk = ~pclk;

    // source edge every 4 cycles, gate period 32 cycles
    always @(posedge pclk)
    begin
        ph <= ph + 5'h01;
        src_in <= ph[1];
        gate_in <= gate_en & ph[4];
    end

    cnt_core #(.UNIT_CYCLES(UNIT)) u_cnt_core (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_in(src_in),
        .gate_in(gate_in), .dout(dout));
    ctrl_board u_ctrl_board (.pclk(pclk), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata));

    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic t_reset();
        u_ctrl_board.xfer(1'b0, cnt_pkg::OFS_IN0, 32'h0, q0, e);
        check(q0, 32'h00008000);
        u_ctrl_board.xfer(1'b0, cnt_pkg::OFS_STAT, 32'h0, q0, e);
        check(q0, 32'h0);
        u_ctrl_board.xfer(1'b0, 8'h14, 32'h0, q0, e);
        check({q0[30:0], e}, 32'h1);
        u_ctrl_board.idle();
        $display("test reset done");
    endtask

    // settings and presets before modes, then control codes
    task automatic t_codes();
        logic [5:0] c[11] = '{6'h10, 6'h14, 6'h0c, 6'h04, 6'h05, 6'h06, 6'h07,
                              6'h08, 6'h09, 6'h0a, 6'h0f};
        foreach (c[i])
        begin
            u_ctrl_board.cmd(16'h0000, {c[i], 10'h000}, q0, q1);
            check({q0[14:0]}, {c[i][4:0], 10'h000});
            check(q1, c[i] == 6'h0f ? {16'h0, cnt_pkg::FW_VERSION} : 32'h0);
        end
        u_ctrl_board.cmd(16'h0000, 16'h0400, q0, q1);
        check(q0[15], 1'b1);
        u_ctrl_board.xfer(1'b0, cnt_pkg::OFS_STAT, 32'h0, q0, e);
        u_ctrl_board.idle();
        check(q0[2:0], 3'h4);
        $display("test codes done");
    endtask

    task automatic t_params();
        logic [9:0] p[5] = '{10'h000, 10'h3e9, 10'h3fb, 10'h001, 10'h3e8};
        foreach (p[i])
        begin
            u_ctrl_board.cmd(16'h0000, {6'h04, p[i]}, q0, q1);
            check(q0[15:0], {i < 3, 5'h04, p[i]});
        end
        $display("test params done");
    endtask

    task automatic t_meas();
        logic [9:0] p[5] = '{10'h002, 10'h3fc, 10'h3fd, 10'h3fe, 10'h3ff};
        logic [31:0] x[5] = '{32'h0000000a, 32'h00000004, 32'h00000004, 32'h00000008,
                              32'h00000008};
        foreach (p[i])
        begin
            gate_en <= i > 0;
            u_ctrl_board.cmd(16'hffff, {6'h04, p[i]}, q0, q1);
            u_ctrl_board.cmd(16'h0000, 16'h0000, q0, q1);
            repeat (100) @(posedge pclk);
            u_ctrl_board.xfer(1'b0, cnt_pkg::OFS_IN0, 32'h0, q0, e);
            u_ctrl_board.xfer(1'b0, cnt_pkg::OFS_IN1, 32'h0, q1, e);
            u_ctrl_board.idle();
            check(q0 & 32'hfffffdff, 32'h0);
            check(q1, x[i]);
        end
        $display("test measure done");
    endtask

    // presets, counting past the final value, then stop, default and start
    task automatic t_out();
        gate_en <= 1'b0;
        u_ctrl_board.cmd(16'h0003, {6'h10, 10'h000}, q0, q1);
        u_ctrl_board.cmd(16'h0008, {6'h14, 10'h000}, q0, q1);
        u_ctrl_board.cmd(16'h0000, {6'h04, 10'h3fd}, q0, q1);
        check({31'h0, dout}, 32'h0);
        repeat (100) @(posedge pclk);
        check({31'h0, dout}, 32'h1);
        u_ctrl_board.cmd(16'h0000, 16'h0000, q0, q1);
        check(q0, 32'h00000100);
        check(q1, 32'h0);
        u_ctrl_board.cmd(16'h0000, {6'h08, 10'h000}, q0, q1);
        u_ctrl_board.cmd(16'h0000, {6'h0a, 10'h000}, q0, q1);
        check({31'h0, dout}, 32'h0);
        repeat (40) @(posedge pclk);
        check({31'h0, dout}, 32'h0);
        u_ctrl_board.cmd(16'h0000, {6'h09, 10'h000}, q0, q1);
        repeat (40) @(posedge pclk);
        check({31'h0, dout}, 32'h1);
        $display("test output done");
    endtask

    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_codes();
        t_params();
        t_meas();
        t_out();
        print_verdict();
    end

    // watchdog well beyond the expected run
    initial
    begin
        repeat (20000) @(posedge pclk);
        errors++;
        print_verdict();
    end
endmodule

// ===== hdl/cnt_core.sv
`timescale 1ns/1ps
// Overview of operation
// - code bits 15..10 of word zero; 04..07 pick frequency, event, time, pulse.
// - code 08 stops, 09 starts, 0a returns counter to its default value.
// - code 0c is system settings, code 0f reports firmware version.
// - code 10 presets initial value, 14 presets final value, 24 bits each.
// - read counter, code 00, places count results into the input words.
// - frequency measurement begins on the mode command, no start needed.
// - frequency mode ignores output word one.
// - parameter 1..1000 is time gated, 1020..1023 is gate-state controlled.
// - at gate expiry or gate condition the counter returns to initial value.
// - gate time equals factor times 10 ms.
// - factor accepted from one up to one thousand inclusive.
// - 1020 counts while gate high, latches on fall, restarts at next high.
// - 1021 counts while gate low, latches on rise, restarts at next low.
// - 1022 counts from command, latches and clears on every rising gate edge.
// - 1023 counts from command, latches and clears on every falling gate edge.
// - gate condition already true at command starts the first count at once.
// - bit 15 of input word zero flags unconfigured, bad parameter or bad read.
// - other commands echo code and parameters into the input words.
// - after read, 24-bit result over word zero bits 7..0 and word one.
module cnt_core #(
    parameter int UNIT_CYCLES = cnt_pkg::UNIT_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic src_in,
    input wire logic gate_in,
    output logic dout
);

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [15:0] out0;
        logic [15:0] out1;
        logic [15:0] in0;
        logic [15:0] in1;
        logic [31:0] prdata;
        cnt_pkg::mode_t mode;
        logic [9:0] fparam;
        logic [23:0] init_val;
        logic [23:0] final_val;
        logic [23:0] count;
        logic [23:0] result;
        logic running;
        logic show_count;
        logic err;
        logic configured;
        logic src_s1;
        logic src_s2;
        logic src_s3;
        logic gate_s1;
        logic gate_s2;
        logic gate_s3;
        logic dout;
    } core_t;

    core_t s_r;
    core_t s_nxt;
    logic restart;
    logic time_en;
    logic expire;
    logic wr_acc;
    logic rd_setup;
    logic addr_ok;
    logic src_rise;
    logic gate_rise;
    logic gate_fall;
    logic [5:0] code;
    logic [9:0] par;
    logic par_time;
    logic par_gate;
    logic freq_ok;
    logic wr_cmd;
    logic [31:0] stat_word;

    ////////////////////////////////////////////////////////////////////////
    // bus decode

    // mapped addresses
    always_comb
    begin
        unique case (paddr)
            cnt_pkg::OFS_OUT0,
            cnt_pkg::OFS_OUT1,
            cnt_pkg::OFS_IN0,
            cnt_pkg::OFS_IN1,
            cnt_pkg::OFS_STAT: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    // zero wait states, read data captured in setup
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign prdata = s_r.prdata;
    assign wr_acc = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign dout = s_r.dout;

    // command fields of incoming word zero
    assign code = pwdata[cnt_pkg::CODE_MSB:cnt_pkg::CODE_LSB];
    assign par = pwdata[cnt_pkg::PARAM_MSB:0];
    assign par_time = (par >= cnt_pkg::FACTOR_MIN) && (par <= cnt_pkg::FACTOR_MAX);
    assign par_gate = (par >= cnt_pkg::GATE_HIGH);
    assign freq_ok = par_time || par_gate;

    // synchronised pin edges
    assign src_rise = s_r.src_s2 & ~s_r.src_s3;
    assign gate_rise = s_r.gate_s2 & ~s_r.gate_s3;
    assign gate_fall = ~s_r.gate_s2 & s_r.gate_s3;

    // word zero write carries a command
    assign wr_cmd = wr_acc && (paddr == cnt_pkg::OFS_OUT0);

    // restart the gate timer only on an accepted frequency command
    assign restart = wr_cmd && (code == cnt_pkg::CMD_FREQ)
        && freq_ok;

    // only time-controlled factors run the timer
    assign time_en = (s_r.mode == cnt_pkg::MODE_FREQ) && s_r.running
        && (s_r.fparam <= cnt_pkg::FACTOR_MAX);

    // status word: configured, running, error and mode
    assign stat_word = {24'h000000, 2'h0, s_r.configured, s_r.running, s_r.err,
        s_r.mode};

    ////////////////////////////////////////////////////////////////////////
    // gate time generator

    gate_timer #(
        .UNIT_CYCLES(UNIT_CYCLES)
    ) u_gate_timer (
        .pclk(pclk),
        .presetn(presetn),
        .restart(restart),
        .enable(time_en),
        .factor(s_r.fparam),
        .expire(expire)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        s_nxt = s_r;

        // two-flop pin synchronisers plus an edge stage
        s_nxt.src_s1 = src_in;
        s_nxt.src_s2 = s_r.src_s1;
        s_nxt.src_s3 = s_r.src_s2;
        s_nxt.gate_s1 = gate_in;
        s_nxt.gate_s2 = s_r.gate_s1;
        s_nxt.gate_s3 = s_r.gate_s2;

        // frequency measurement counting
        // source edges count while the gate condition holds
        if (s_r.mode == cnt_pkg::MODE_FREQ && s_r.running)
        begin
            unique case (s_r.fparam)
                cnt_pkg::GATE_HIGH:
                begin
                    if (gate_fall)
                    begin
                        s_nxt.result = s_r.count;
                        s_nxt.count = s_r.init_val;
                    end
                    else if (s_r.gate_s2 && src_rise)
                        s_nxt.count = s_r.count + 24'h000001;
                end
                cnt_pkg::GATE_LOW:
                begin
                    if (gate_rise)
                    begin
                        s_nxt.result = s_r.count;
                        s_nxt.count = s_r.init_val;
                    end
                    else if (!s_r.gate_s2 && src_rise)
                        s_nxt.count = s_r.count + 24'h000001;
                end
                cnt_pkg::GATE_RISE,
                cnt_pkg::GATE_FALL:
                begin
                    if ((s_r.fparam == cnt_pkg::GATE_RISE) ? gate_rise : gate_fall)
                    begin
                        s_nxt.result = s_r.count;
                        s_nxt.count = src_rise ? s_r.init_val + 24'h000001 : s_r.init_val;
                    end
                    else if (src_rise)
                        s_nxt.count = s_r.count + 24'h000001;
                end
                default:
                begin
                    if (expire)
                    begin
                        s_nxt.result = s_r.count;
                        s_nxt.count = src_rise ? s_r.init_val + 24'h000001 : s_r.init_val;
                    end
                    else if (src_rise)
                        s_nxt.count = s_r.count + 24'h000001;
                end
            endcase
        end

        // digital output from the final-value relation
        s_nxt.dout = (s_r.final_val != cnt_pkg::VAL_RST) && (s_r.count >= s_r.final_val);

        // live count results while the read command stands
        if (s_r.show_count)
        begin
            s_nxt.in0 = {cnt_pkg::CMD_READ, s_r.gate_s2, s_r.dout, s_nxt.result[23:16]};
            s_nxt.in1 = s_nxt.result[15:0];
        end

        // register writes; word zero carries the command
        if (wr_acc && paddr == cnt_pkg::OFS_OUT1)
            s_nxt.out1 = pwdata[15:0];
        if (wr_cmd)
        begin
            s_nxt.out0 = pwdata[15:0];
            s_nxt.err = 1'b0;
            s_nxt.show_count = 1'b0;
            s_nxt.in0 = pwdata[15:0];
            s_nxt.in1 = cnt_pkg::WORD_RST;
            // command decode; codes outside the table are refused
            unique case (code)
                cnt_pkg::CMD_READ:
                begin
                    if (s_r.mode == cnt_pkg::MODE_NONE)
                    begin
                        s_nxt.err = 1'b1;
                        s_nxt.in0 = {cnt_pkg::CMD_READ, 10'h000};
                    end
                    else
                    begin
                        s_nxt.show_count = 1'b1;
                        s_nxt.in0 = {cnt_pkg::CMD_READ, s_r.gate_s2, s_r.dout, s_r.result[23:16]};
                        s_nxt.in1 = s_r.result[15:0];
                    end
                end
                cnt_pkg::CMD_FREQ:
                begin
                    if (freq_ok)
                    begin
                        s_nxt.mode = cnt_pkg::MODE_FREQ;
                        s_nxt.fparam = par;
                        s_nxt.running = 1'b1;
                        s_nxt.configured = 1'b1;
                        s_nxt.count = s_r.init_val;
                        s_nxt.result = cnt_pkg::VAL_RST;
                    end
                    else
                    begin
                        s_nxt.err = 1'b1;
                    end
                end
                cnt_pkg::CMD_EVENT,
                cnt_pkg::CMD_TIME,
                cnt_pkg::CMD_PULSE:
                begin
                    // other modes share the decoder only
                    s_nxt.mode = (code == cnt_pkg::CMD_EVENT) ? cnt_pkg::MODE_EVENT :
                        (code == cnt_pkg::CMD_TIME) ? cnt_pkg::MODE_TIME : cnt_pkg::MODE_PULSE;
                    s_nxt.configured = 1'b1;
                    s_nxt.running = 1'b0;
                end
                cnt_pkg::CMD_STOP:
                    s_nxt.running = 1'b0;
                cnt_pkg::CMD_START:
                begin
                    s_nxt.running = 1'b1;
                    s_nxt.err = ~s_r.configured;
                end
                cnt_pkg::CMD_DEFAULT:
                    s_nxt.count = s_r.init_val;
                cnt_pkg::CMD_SYS:
                    s_nxt.in1 = s_r.out1;
                cnt_pkg::CMD_FWVER:
                    s_nxt.in1 = cnt_pkg::FW_VERSION;
                cnt_pkg::CMD_PRE_INIT:
                begin
                    s_nxt.init_val = {pwdata[7:0], s_r.out1};
                    s_nxt.in1 = s_r.out1;
                end
                cnt_pkg::CMD_PRE_FINAL:
                begin
                    s_nxt.final_val = {pwdata[7:0], s_r.out1};
                    s_nxt.in1 = s_r.out1;
                end
                default:
                begin
                    s_nxt.err = 1'b1;
                end
            endcase
            // error flag shares bit 15, whose code bit is always zero
            s_nxt.in0[cnt_pkg::ERR_BIT] = s_nxt.err | ~s_nxt.configured;
        end

        // read data captured in setup phase
        if (rd_setup)
        begin
            unique case (paddr)
                cnt_pkg::OFS_OUT0: s_nxt.prdata = {16'h0000, s_r.out0};
                cnt_pkg::OFS_OUT1: s_nxt.prdata = {16'h0000, s_r.out1};
                cnt_pkg::OFS_IN0: s_nxt.prdata = {16'h0000, s_r.in0};
                cnt_pkg::OFS_IN1: s_nxt.prdata = {16'h0000, s_r.in1};
                cnt_pkg::OFS_STAT: s_nxt.prdata = stat_word;
                default: s_nxt.prdata = 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_r <= '0;
            s_r.in0 <= cnt_pkg::IN0_RST; // unconfigured flag
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

endmodule

// ===== hdl/cnt_pkg.sv
package cnt_pkg;

    // apb register byte offsets
    localparam logic [7:0] OFS_OUT0 = 8'h00;
    localparam logic [7:0] OFS_OUT1 = 8'h04;
    localparam logic [7:0] OFS_IN0 = 8'h08;
    localparam logic [7:0] OFS_IN1 = 8'h0c;
    localparam logic [7:0] OFS_STAT = 8'h10;

    // command codes, bits 15..10 of output word zero
    localparam logic [5:0] CMD_READ = 6'h00;
    localparam logic [5:0] CMD_FREQ = 6'h04;
    localparam logic [5:0] CMD_EVENT = 6'h05;
    localparam logic [5:0] CMD_TIME = 6'h06;
    localparam logic [5:0] CMD_PULSE = 6'h07;
    localparam logic [5:0] CMD_STOP = 6'h08;
    localparam logic [5:0] CMD_START = 6'h09;
    localparam logic [5:0] CMD_DEFAULT = 6'h0a;
    localparam logic [5:0] CMD_SYS = 6'h0c;
    localparam logic [5:0] CMD_FWVER = 6'h0f;
    localparam logic [5:0] CMD_PRE_INIT = 6'h10;
    localparam logic [5:0] CMD_PRE_FINAL = 6'h14;

    // field positions
    localparam int CODE_MSB = 15;
    localparam int CODE_LSB = 10;
    localparam int ERR_BIT = 15;
    localparam int GATE_BIT = 9;
    localparam int OUT_BIT = 8;
    localparam int PARAM_MSB = 9;
    localparam int VAL_W = 24;

    // frequency parameter limits
    localparam logic [9:0] FACTOR_MIN = 10'h001;
    localparam logic [9:0] FACTOR_MAX = 10'h3e8;
    localparam logic [9:0] GATE_HIGH = 10'h3fc;
    localparam logic [9:0] GATE_LOW = 10'h3fd;
    localparam logic [9:0] GATE_RISE = 10'h3fe;
    localparam logic [9:0] GATE_FALL = 10'h3ff;

    // reset values
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [15:0] IN0_RST = 16'h8000;
    localparam logic [23:0] VAL_RST = 24'h000000;
    localparam logic [15:0] FW_VERSION = 16'h0100; // arbitrary value

    // gate time unit: 10 ms at 200 MHz
    localparam int GATE_UNIT_MS = 10;
    localparam int CLK_MHZ = 200;
    localparam int UNIT_CYCLES = GATE_UNIT_MS * 1000 * CLK_MHZ;

    // operating modes
    typedef enum logic [2:0]
    {
        MODE_NONE = 3'b000,
        MODE_FREQ = 3'b001,
        MODE_EVENT = 3'b010,
        MODE_TIME = 3'b011,
        MODE_PULSE = 3'b100
    } mode_t;

endpackage

// ===== hdl/gate_timer.sv
`timescale 1ns/1ps
// cycle divider to a 10 ms tick, then a tick count up to the factor
module gate_timer #(
    parameter int UNIT_CYCLES = cnt_pkg::UNIT_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic restart,
    input wire logic enable,
    input wire logic [9:0] factor,
    output logic expire
);

    typedef struct packed {
        logic [31:0] cyc;
        logic [9:0] ticks;
        logic expire;
    } tmr_t;

    tmr_t s_r;
    tmr_t s_nxt;

    // next-state: divider enable pulse, then gate-time count
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.expire = 1'b0;
        if (restart || !enable)
        begin
            s_nxt.cyc = 32'h00000000;
            s_nxt.ticks = 10'h000;
        end
        else if (s_r.cyc == 32'(UNIT_CYCLES - 1))
        begin
            s_nxt.cyc = 32'h00000000;
            if (s_r.ticks + 10'h001 >= factor)
            begin
                s_nxt.ticks = 10'h000;
                s_nxt.expire = 1'b1;
            end
            else
            begin
                s_nxt.ticks = s_r.ticks + 10'h001;
            end
        end
        else
        begin
            s_nxt.cyc = s_r.cyc + 32'h00000001;
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign expire = s_r.expire;

endmodule
